// ==== hdl/bft_pkg.sv ====
// Shared constants for the breaker failure timer logic.
// Assumes a 10 MHz clock and a 5 ms protection evaluation cycle.
package bft_pkg;

    // Clock and evaluation cycle timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int EVAL_PERIOD_NS = 5_000_000;
    localparam int EVAL_CYCLES_DEF = EVAL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int EVAL_DIV_W = 16;

    // Delay settings are counted in evaluation steps of 5 ms.
    localparam int DELAY_W = 19;
    localparam int DELAY_STEP_MS = 5;
    localparam int RETRIP_DELAY_DEF_MS = 100;
    localparam int CBF_DELAY_DEF_MS = 200;
    localparam logic [DELAY_W-1:0] RETRIP_DELAY_DEF =
        DELAY_W'(RETRIP_DELAY_DEF_MS / DELAY_STEP_MS);
    localparam logic [DELAY_W-1:0] CBF_DELAY_DEF =
        DELAY_W'(CBF_DELAY_DEF_MS / DELAY_STEP_MS);

    localparam int CUR_W = 16;

    // Criterion select codes.
    localparam logic [3:0] CRIT_CURRENT = 4'h0;
    localparam logic [3:0] CRIT_CUR_AND_CONTACT = 4'h3;
    localparam logic [3:0] CRIT_CUR_OR_CONTACT = 4'h4;
    localparam logic [3:0] CRIT_RESET = CRIT_CURRENT;
    localparam logic RETRIP_EN_RESET = 1'b1;

    // Condition codes shown on the status output.
    localparam logic [2:0] COND_NORMAL = 3'h0;
    localparam logic [2:0] COND_START = 3'h1;
    localparam logic [2:0] COND_RETRIP = 3'h2;
    localparam logic [2:0] COND_CBF_ON = 3'h3;
    localparam logic [2:0] COND_BLOCKED = 3'h4;

    // True when a measured magnitude exceeds its pick-up threshold.
    function automatic logic over_thr(input logic [CUR_W-1:0] meas,
                                      input logic [CUR_W-1:0] thr);
        return meas > thr;
    endfunction

    // True when one more step reaches the programmed delay.
    function automatic logic step_reaches(input logic [DELAY_W-1:0] cnt,
                                          input logic [DELAY_W-1:0] dly);
        return ({1'b0, cnt} + {{DELAY_W{1'b0}}, 1'b1}) >= {1'b0, dly};
    endfunction

endpackage

// ==== hdl/bft_tmr_if.sv ====
// Link between the supervision logic and one delay timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface bft_tmr_if;
    import bft_pkg::*;
    logic tick;
    logic run;
    logic clear;
    logic [DELAY_W-1:0] delay;
    logic [DELAY_W-1:0] count;
    logic expire_now;
    modport ctl(output tick, run, clear, delay, input count, expire_now);
    modport tmr(input tick, run, clear, delay, output count, expire_now);
endinterface

// ==== hdl/bft_delay_timer.sv ====
// One evaluation-cycle delay timer whose count saturates one step below the delay.
// Assumes a reset already synchronised to i_clk.
`timescale 1ns/1ps
module bft_delay_timer
    import bft_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    bft_tmr_if.tmr tif
);
    logic [DELAY_W-1:0] cnt_r;
    logic [DELAY_W-1:0] cnt_nxt;
    logic reach;

    assign reach = step_reaches(cnt_r, tif.delay);
    // Expiry is seen in the same step in which the last tick lands.
    assign tif.expire_now = tif.run & reach;
    assign tif.count = cnt_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (tif.clear) begin
            cnt_nxt = '0;
        end else if (tif.tick) begin
            if (!tif.run) begin
                cnt_nxt = '0;
            end else if (!reach) begin
                cnt_nxt = cnt_r + DELAY_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // bft_delay_timer

// ==== hdl/bft_supervisor.sv ====
// Breaker failure supervision: pick-up, blocking, retrip and failure delay.
// Assumes current magnitudes arrive on i_clk; the trip contact readback and
// the blocking input are pins and are synchronised here.
`timescale 1ns/1ps

module bft_supervisor
    import bft_pkg::*;
#(
    parameter int P_EVAL_CYCLES = EVAL_CYCLES_DEF
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sync_clear,
    input wire logic [CUR_W-1:0] i_phase_current,
    input wire logic [CUR_W-1:0] i_residual_current,
    input wire logic [CUR_W-1:0] i_phase_pickup_threshold,
    input wire logic [CUR_W-1:0] i_residual_pickup_threshold,
    input wire logic i_trip_contact,
    input wire logic i_block,
    input wire logic i_primary_trip_cmd,
    input wire logic i_settings_load,
    input wire logic [3:0] i_criterion,
    input wire logic i_retrip_en,
    input wire logic [DELAY_W-1:0] i_redundant_coil_delay,
    input wire logic [DELAY_W-1:0] i_breaker_failure_delay,
    output logic o_main_trip,
    output logic o_retrip,
    output logic o_breaker_failure_command,
    output logic o_start,
    output logic o_blocked,
    output logic [2:0] o_condition
);
    localparam logic [EVAL_DIV_W-1:0] EVAL_LAST =
        EVAL_DIV_W'(P_EVAL_CYCLES - 1);

    // Reset release synchroniser.
    logic [1:0] rst_pipe_r;
    logic rst_b_s;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_b_s = rst_pipe_r[1];

    // Pin synchronisers: bit 0 trip contact, bit 1 block.
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic [1:0] pin_s3_r;
    logic [1:0] pin_flt_r;
    logic [1:0] pin_agree;
    logic contact_s;
    logic block_s;

    assign pin_agree = ~(pin_s2_r ^ pin_s3_r);

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            pin_s3_r <= 2'h0;
            pin_flt_r <= 2'h0;
        end else begin
            pin_s1_r <= {i_block, i_trip_contact};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_flt_r <= (pin_agree & pin_s3_r) | (~pin_agree & pin_flt_r);
        end
    end
    assign contact_s = pin_flt_r[0];
    assign block_s = pin_flt_r[1];

    // Evaluation cycle divider.
    logic [EVAL_DIV_W-1:0] div_r;
    logic tick_r;
    logic div_wrap;

    assign div_wrap = (div_r == EVAL_LAST);

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_wrap ? '0 : div_r + EVAL_DIV_W'(1);
            tick_r <= div_wrap;
        end
    end

    // Settings, taken together on a load strobe.
    logic [3:0] crit_r;
    logic rt_en_r;
    logic [DELAY_W-1:0] rt_dly_r;
    logic [DELAY_W-1:0] cbf_dly_r;

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            crit_r <= CRIT_RESET;
            rt_en_r <= RETRIP_EN_RESET;
            rt_dly_r <= RETRIP_DELAY_DEF;
            cbf_dly_r <= CBF_DELAY_DEF;
        end else if (i_settings_load) begin
            crit_r <= i_criterion;
            rt_en_r <= i_retrip_en;
            rt_dly_r <= i_redundant_coil_delay;
            cbf_dly_r <= i_breaker_failure_delay;
        end
    end

    // Pick-up and timing conditions per criterion.
    logic cur_over;
    logic mode_cur;
    logic mode_and;
    logic mode_or;
    logic pickup;
    logic timing;

    assign cur_over = over_thr(i_phase_current, i_phase_pickup_threshold) |
        over_thr(i_residual_current, i_residual_pickup_threshold);
    assign mode_cur = (crit_r == CRIT_CURRENT);
    assign mode_and = (crit_r == CRIT_CUR_AND_CONTACT);
    assign mode_or = (crit_r == CRIT_CUR_OR_CONTACT);

    // The contact is ignored in current-only mode.
    assign pickup = (mode_cur & cur_over)
        | (mode_and & cur_over)
        | (mode_or & (cur_over | contact_s));

    // Current-and-contact halts timing until the contact is seen.
    assign timing = (mode_cur & cur_over)
        | (mode_and & cur_over & contact_s)
        | (mode_or & (cur_over | contact_s));

    // Start and blocked indications.
    logic start_r;
    logic blocked_r;
    logic start_nxt;
    logic blocked_nxt;
    logic run;

    // Once blocked at pick-up, the event is not timed until pick-up drops.
    assign start_nxt = pickup & ~block_s & ~blocked_r;
    assign blocked_nxt = pickup & (block_s | blocked_r);
    assign run = timing & start_nxt;

    // Delay timers.
    bft_tmr_if rt_if ();
    bft_tmr_if cf_if ();

    assign rt_if.tick = tick_r;
    assign rt_if.run = run & rt_en_r;
    assign rt_if.clear = i_sync_clear;
    assign rt_if.delay = rt_dly_r;
    assign cf_if.tick = tick_r;
    assign cf_if.run = run;
    assign cf_if.clear = i_sync_clear;
    assign cf_if.delay = cbf_dly_r;

    bft_delay_timer u_retrip_tmr (
        .i_clk(i_clk),
        .i_rst_b(rst_b_s),
        .tif(rt_if.tmr)
    );

    bft_delay_timer u_cbf_tmr (
        .i_clk(i_clk),
        .i_rst_b(rst_b_s),
        .tif(cf_if.tmr)
    );

    // Output stage, updated once per evaluation step and cleared on any clock by i_sync_clear; the main trip follows the command every clock.
    logic retrip_r;
    logic cbf_r;
    logic main_trip_r;
    logic [2:0] cond_r;
    logic [2:0] cond_nxt;
    logic retrip_nxt;
    logic cbf_nxt;

    assign retrip_nxt = rt_if.expire_now & rt_en_r;
    assign cbf_nxt = cf_if.expire_now;
    assign cond_nxt = cbf_nxt ? COND_CBF_ON :
        retrip_nxt ? COND_RETRIP :
        start_nxt ? COND_START :
        blocked_nxt ? COND_BLOCKED : COND_NORMAL;

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            main_trip_r <= 1'b0;
        end else begin
            main_trip_r <= i_primary_trip_cmd;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b_s) begin
        if (!rst_b_s) begin
            retrip_r <= 1'b0;
            cbf_r <= 1'b0;
            start_r <= 1'b0;
            blocked_r <= 1'b0;
            cond_r <= COND_NORMAL;
        end else if (i_sync_clear) begin
            retrip_r <= 1'b0;
            cbf_r <= 1'b0;
            start_r <= 1'b0;
            blocked_r <= 1'b0;
            cond_r <= COND_NORMAL;
        end else if (tick_r) begin
            retrip_r <= retrip_nxt;
            cbf_r <= cbf_nxt;
            start_r <= start_nxt;
            blocked_r <= blocked_nxt;
            cond_r <= cond_nxt;
        end
    end

    assign o_main_trip = main_trip_r;
    assign o_retrip = retrip_r;
    assign o_breaker_failure_command = cbf_r;
    assign o_start = start_r;
    assign o_blocked = blocked_r;
    assign o_condition = cond_r;

    // Checks on the supervision behaviour.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_b_s);

    sequence s_step_cur_high;
        tick_r && !i_sync_clear && mode_cur && cur_over && !block_s
            && !blocked_r;
    endsequence

    sequence s_step_and_no_contact;
        tick_r && !i_sync_clear && mode_and && cur_over && !contact_s;
    endsequence

    sequence s_step_or_contact;
        tick_r && !i_sync_clear && mode_or && contact_s && !block_s
            && !blocked_r;
    endsequence

    sequence s_tick_then_quiet;
        tick_r ##1 !tick_r [*2];
    endsequence

    AST_CUR_START: assert property (
        s_step_cur_high |=> o_start && o_condition != COND_NORMAL)
        else $error("current pick-up did not start");

    AST_CUR_RESET: assert property (
        tick_r && mode_cur && !cur_over |=> !o_retrip
            && !o_breaker_failure_command && rt_if.count == '0)
        else $error("current drop did not reset timers");

    AST_AND_HALT: assert property (
        s_step_and_no_contact |=> cf_if.count == '0
            && !o_breaker_failure_command)
        else $error("timer ran without trip contact");

    AST_OR_CONTACT: assert property (
        s_step_or_contact |=> o_start)
        else $error("contact alone did not hold pick-up");

    AST_RETRIP_GATE: assert property (
        tick_r && !rt_en_r |=> !o_retrip)
        else $error("retrip asserted while disabled");

    AST_BLOCKED: assert property (
        tick_r && !i_sync_clear && pickup && block_s
            |=> o_blocked && !o_start && o_condition == COND_BLOCKED)
        else $error("block at pick-up not indicated");

    AST_SYNC_CLEAR: assert property (
        i_sync_clear |=> !o_retrip && !o_breaker_failure_command
            && !o_start && cf_if.count == '0)
        else $error("synchronous clear left state");

    AST_TICK_SPACING: assert property (
        s_tick_then_quiet |-> $stable(cf_if.count) || $past(i_sync_clear))
        else $error("timer moved between evaluation steps");

    AST_CBF_CAUSE: assert property (
        $rose(o_breaker_failure_command) |-> $past(cf_if.expire_now)
            && $past(tick_r))
        else $error("failure output without expiry");

    AST_MAIN_TRIP: assert property (
        i_primary_trip_cmd |=> o_main_trip)
        else $error("main trip did not follow command");

    AST_OUT_DROP: assert property (
        tick_r && !run |=> !o_retrip && !o_breaker_failure_command)
        else $error("output held after timer reset");

    sequence s_step_and_contact;
        tick_r && !i_sync_clear && mode_and && cur_over && contact_s
            && !block_s && !blocked_r;
    endsequence

    sequence s_step_or_either;
        tick_r && !i_sync_clear && mode_or && (cur_over || contact_s)
            && !block_s && !blocked_r;
    endsequence

    AST_AND_RUN: assert property (
        s_step_and_contact |=> o_start
            && (cf_if.count != '0 || o_breaker_failure_command))
        else $error("contact and current did not time");

    AST_AND_DROP: assert property (
        tick_r && mode_and && !contact_s |=> !o_retrip
            && !o_breaker_failure_command && cf_if.count == '0)
        else $error("contact drop did not reset timers");

    AST_OR_HOLD: assert property (
        s_step_or_either |=> o_start
            && (cf_if.count != '0 || o_breaker_failure_command))
        else $error("either condition did not keep timing");

    AST_RETRIP_CAUSE: assert property (
        $rose(o_retrip) |-> $past(rt_if.expire_now) && $past(tick_r)
            && $past(rt_en_r))
        else $error("retrip output without expiry");

    AST_CBF_ON_EXPIRY: assert property (
        tick_r && !i_sync_clear && cf_if.expire_now
            |=> o_breaker_failure_command)
        else $error("failure expiry did not drive output");

    AST_BLOCK_IDLE: assert property (
        o_blocked |-> rt_if.count == '0 && cf_if.count == '0)
        else $error("timers ran while blocked");

endmodule // bft_supervisor

// ==== verif/bft_breaker_model.sv ====
// Far side model: the main trip contact readback as seen by the supervisor.
// Assumes the main trip output drives a contact that closes one or three
// clocks later, chosen by i_slow.
`timescale 1ns/1ps
module bft_breaker_model (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_main_trip,
    output logic o_trip_contact
);
    logic [2:0] dly_r = 3'h0;

    always_ff @(posedge i_clk) begin
        dly_r <= {dly_r[1:0], i_main_trip};
    end

    assign o_trip_contact = i_slow ? dly_r[2] : dly_r[0];
endmodule // bft_breaker_model

// ==== verif/bft_supervisor_tb.sv ====
// Self-checking bench for the breaker failure supervision logic.
// Assumes an evaluation tick every 8 clocks and delays of 4 and 8 ticks.
`timescale 1ns/1ps
module bft_supervisor_tb;
    import bft_pkg::*;
    localparam int EV = 8;
    logic clk, rst_b, clr, contact, blk, cmd, load, ren, slow;
    logic [CUR_W-1:0] ph, rs, ph_thr, rs_thr;
    logic [3:0] crit;
    logic [DELAY_W-1:0] rt_dly, cbf_dly;
    logic main_trip, retrip, cbf, start, blocked;
    logic [2:0] cond;
    int error_cnt;
    int total_checks;
    logic [7:0] exp_q[$];
    event chk_ev;

    bft_supervisor #(.P_EVAL_CYCLES(EV)) bft_supervisor_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_sync_clear(clr),
        .i_phase_current(ph), .i_residual_current(rs),
        .i_phase_pickup_threshold(ph_thr),
        .i_residual_pickup_threshold(rs_thr),
        .i_trip_contact(contact), .i_block(blk),
        .i_primary_trip_cmd(cmd), .i_settings_load(load),
        .i_criterion(crit), .i_retrip_en(ren),
        .i_redundant_coil_delay(rt_dly), .i_breaker_failure_delay(cbf_dly),
        .o_main_trip(main_trip), .o_retrip(retrip),
        .o_breaker_failure_command(cbf), .o_start(start),
        .o_blocked(blocked), .o_condition(cond)
    );

    bft_breaker_model bft_breaker_model_i (
        .i_clk(clk), .i_slow(slow), .i_main_trip(main_trip),
        .o_trip_contact(contact)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Expected status code follows the priority failure, retrip, start, block.
    function automatic logic [7:0] rec(logic s, logic b, logic r, logic f,
                                       logic m);
        return {s, b, r, f, m,
                f ? COND_CBF_ON : r ? COND_RETRIP : s ? COND_START :
                b ? COND_BLOCKED : COND_NORMAL};
    endfunction

    initial begin
        logic [7:0] got;
        logic [7:0] e;
        forever begin
            @(chk_ev);
            got = {start, blocked, retrip, cbf, main_trip, cond};
            e = exp_q.pop_front();
            total_checks++;
            if (got !== e) begin
                error_cnt++;
                $display("[ERR] %0t outputs %b expected %b", $time, got, e);
            end
        end
    end

    task automatic note(input logic [7:0] e);
        @(negedge clk);
        exp_q.push_back(e);
        -> chk_ev;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic load_set(input logic [3:0] c, input logic e);
        @(posedge clk);
        crit <= c;
        ren <= e;
        rt_dly <= 19'h0_0004;
        cbf_dly <= 19'h0_0008;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
    endtask

    // Over picks phase or residual at random; not over may sit exactly
    // on the threshold, which must not count as exceeded.
    task automatic set_cond(input logic over, input logic c);
        logic [CUR_W-1:0] thr;
        logic [CUR_W-1:0] d;
        logic [CUR_W-1:0] hi;
        logic [CUR_W-1:0] lo;
        logic use_res;
        thr = CUR_W'(100 + $urandom_range(30000));
        d = CUR_W'($urandom_range(1, 99));
        use_res = 1'($urandom_range(1));
        hi = over ? thr + d : thr - d + 16'h0001;
        lo = thr - d + 16'h0001;
        @(posedge clk);
        ph_thr <= thr;
        rs_thr <= thr;
        ph <= use_res ? lo : hi;
        rs <= use_res ? hi : lo;
        cmd <= c;
    endtask

    task automatic scen(input logic [3:0] c, input logic e, input logic over,
                        input logic cm, input logic s, input logic b,
                        input logic r, input logic f);
        load_set(c, e);
        set_cond(over, cm);
        wait_clk(20);
        note(rec(s, b, 1'b0, 1'b0, cm));
        wait_clk(28);
        note(rec(s, b, r, 1'b0, cm));
        wait_clk(32);
        note(rec(s, b, r, f, cm));
    endtask

    task automatic rel(input string name);
        set_cond(1'b0, 1'b0);
        wait_clk(24);
        note(rec(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        $display("test %s done", name);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        wait_clk(20000);
        error_cnt++;
        conclude();
    end

    initial begin
        error_cnt = 0;
        total_checks = 0;
        rst_b = 1'b0;
        clr = 1'b0;
        blk = 1'b0;
        cmd = 1'b0;
        load = 1'b0;
        ren = 1'b1;
        slow = 1'b0;
        crit = 4'h0;
        ph = 16'h0000;
        rs = 16'h0000;
        ph_thr = 16'hffff;
        rs_thr = 16'hffff;
        rt_dly = 19'h0_0004;
        cbf_dly = 19'h0_0008;
        void'($urandom(45492));
        wait_clk(4);
        rst_b <= 1'b1;
        wait_clk(4);
        scen(CRIT_CURRENT, 1'b1, 1'b1, 1'b0,
             1, 0, 1, 1);
        rel("current only");
        scen(CRIT_CURRENT, 1'b1, 1'b0, 1'b1, 0, 0, 0, 0);
        rel("contact ignored");
        scen(CRIT_CUR_AND_CONTACT, 1'b1, 1'b1, 1'b0, 1, 0, 0, 0);
        rel("and halted");
        @(posedge clk);
        slow <= 1'b1;
        scen(CRIT_CUR_AND_CONTACT, 1'b1, 1'b1, 1'b1,
             1, 0, 1, 1);
        set_cond(1'b1, 1'b0);
        wait_clk(24);
        note(rec(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        rel("and contact");
        scen(CRIT_CUR_OR_CONTACT, 1'b1, 1'b0, 1'b1,
             1, 0, 1, 1);
        // Current takes over as the contact drops: timing must not restart.
        set_cond(1'b1, 1'b0);
        wait_clk(24);
        note(rec(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
        rel("or contact");
        @(posedge clk);
        slow <= 1'b0;
        scen(CRIT_CUR_OR_CONTACT, 1'b1, 1'b1, 1'b0,
             1, 0, 1, 1);
        rel("or current");
        scen(CRIT_CURRENT, 1'b0, 1'b1, 1'b0, 1, 0, 0, 1);
        rel("no retrip");
        scen(4'h7, 1'b1, 1'b1, 1'b1, 0, 0, 0, 0);
        rel("unknown code");
        @(posedge clk);
        blk <= 1'b1;
        wait_clk(8);
        scen(CRIT_CURRENT, 1'b1, 1'b1, 1'b0, 0, 1, 0, 0);
        @(posedge clk);
        blk <= 1'b0;
        rel("blocked");
        scen(CRIT_CURRENT, 1'b1, 1'b1, 1'b1, 1, 0, 1, 1);
        @(posedge clk);
        clr <= 1'b1;
        wait_clk(2);
        note(rec(1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        @(posedge clk);
        clr <= 1'b0;
        rel("sync clear");
        wait_clk(2);
        conclude();
    end
endmodule // bft_supervisor_tb
